/* File: bench/pwl_lin_asserts.sv */
// Port assertions for the lineariser editor
`timescale 1ns/100ps
`include "pwl_defs.vh"
module pwl_lin_asserts (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Keys and measurement path
  input wire key_confirm_in,
  input wire key_escape_in,
  input wire linear_under_in,
  input wire linear_over_in,
  input wire factory_restore_in,
  // Status
  input wire under_range_out,
  input wire over_range_out,
  input wire [2:0] menu_state_out,
  input wire [1:0] sub_prompt_out,
  input wire [4:0] point_index_out,
  input wire [4:0] point_total_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_UNDER: assert property (
    !$past(reset_in) |-> under_range_out == $past(linear_under_in))
    else $error("under flag not forwarded");
  AST_OVER: assert property (
    !$past(reset_in) |-> over_range_out == $past(linear_over_in))
    else $error("over flag not forwarded");
  AST_MAX_PTS: assert property (
    point_total_out <= `PWL_LAST_IDX)
    else $error("too many points");
  AST_IDX: assert property (
    point_index_out <= point_total_out)
    else $error("index beyond table");
  // Outside a restore the count only moves by one point at a time
  AST_STEP: assert property (
    !$past(reset_in) && !$past(factory_restore_in)
    && !$past(factory_restore_in, 2)
    && point_total_out != $past(point_total_out) |->
    point_total_out == $past(point_total_out) + 5'h01
    || point_total_out == $past(point_total_out) - 5'h01)
    else $error("count jumped");
  AST_RESTORE: assert property (
    factory_restore_in |-> ##[1:3] point_total_out == 5'h01)
    else $error("restore left wrong count");
  AST_ADD: assert property (
    menu_state_out == `PWL_S_ADD && $rose(key_confirm_in)
    && point_total_out < `PWL_LAST_IDX |->
    ##4 point_total_out == $past(point_total_out, 4) + 5'h01)
    else $error("add did not grow table");
  AST_DEL: assert property (
    menu_state_out == `PWL_S_DEL && $rose(key_confirm_in) |->
    ##4 point_total_out == ($past(point_total_out, 4) == 5'h01 ?
    5'h01 : $past(point_total_out, 4) - 5'h01))
    else $error("delete count wrong");
  AST_ESC_SUB: assert property (
    (menu_state_out == `PWL_S_ADD || menu_state_out == `PWL_S_DEL)
    && $rose(key_escape_in) |-> ##4 menu_state_out == `PWL_S_SUB
    && sub_prompt_out == {1'b0, $past(menu_state_out, 4) == `PWL_S_DEL})
    else $error("wrong prompt after escape");
  AST_ESC_TOP: assert property (
    menu_state_out == `PWL_S_SUB && $rose(key_escape_in) |->
    ##4 menu_state_out == `PWL_S_TOP)
    else $error("escape did not reach top");
endmodule
bind pwl_lineariser pwl_lin_asserts u_chk (
  .clk_in(clk_in), .reset_in(reset_in),
  .key_confirm_in(key_confirm_in), .key_escape_in(key_escape_in),
  .linear_under_in(linear_under_in), .linear_over_in(linear_over_in),
  .factory_restore_in(factory_restore_in),
  .under_range_out(under_range_out), .over_range_out(over_range_out),
  .menu_state_out(menu_state_out), .sub_prompt_out(sub_prompt_out),
  .point_index_out(point_index_out), .point_total_out(point_total_out)
);

/* File: bench/pwl_operator.sv */
// Front-panel operator model that presses one key at a time
`timescale 1ns/100ps
module pwl_operator (
  // Clock
  input wire clk_in,
  // Keys
  output wire key_up_out,
  output wire key_down_out,
  output wire key_confirm_out,
  output wire key_escape_out
);
  reg [3:0] keys_ff;
  assign key_up_out = keys_ff[0];
  assign key_down_out = keys_ff[1];
  assign key_confirm_out = keys_ff[2];
  assign key_escape_out = keys_ff[3];
  initial begin
    keys_ff = 4'h0;
  end
  // Long high and low phases so the two-stage sync never merges presses
  task press(input [1:0] k);
    begin
      @(posedge clk_in);
      keys_ff <= {k == 2'h3, k == 2'h2, k == 2'h1, k == 2'h0};
      repeat (4) @(posedge clk_in);
      keys_ff <= 4'h0;
      repeat (4) @(posedge clk_in);
      #1;
    end
  endtask
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the lineariser and its editor
`timescale 1ns/100ps
`include "pwl_defs.vh"
module tb;
  reg clk_in;
  reg reset_in;
  reg five_digit_in;
  reg lin_enable_in;
  reg [15:0] loop_current_in;
  reg signed [19:0] linear_value_in;
  reg linear_under_in;
  reg linear_over_in;
  reg factory_restore_in;
  wire ku, kd, kc, ke, und, ovr, fail, neg;
  wire signed [19:0] point_display_value_cmd;
  wire [19:0] dig;
  wire [2:0] menu;
  wire [2:0] pos;
  wire [1:0] sub;
  wire [4:0] idx;
  wire [4:0] tot;
  integer fails;
  integer checks_done;
  pwl_operator u_op (.clk_in(clk_in), .key_up_out(ku),
    .key_down_out(kd), .key_confirm_out(kc), .key_escape_out(ke));
  pwl_lineariser u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .key_up_in(ku), .key_down_in(kd), .key_confirm_in(kc),
    .key_escape_in(ke), .five_digit_in(five_digit_in),
    .lin_enable_in(lin_enable_in), .loop_current_in(loop_current_in),
    .linear_value_in(linear_value_in), .linear_under_in(linear_under_in),
    .linear_over_in(linear_over_in),
    .factory_restore_in(factory_restore_in), .display_value_out(point_display_value_cmd),
    .under_range_out(und), .over_range_out(ovr), .menu_state_out(menu),
    .sub_prompt_out(sub), .point_index_out(idx), .point_total_out(tot),
    .edit_digits_out(dig), .edit_negative_out(neg), .fail_out(fail),
    .edit_digit_pos_out(pos));
  task chk(input [19:0] got, input [19:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  // Interpolation is slow, so allow two full results to land
  task meas(input [15:0] x, input [19:0] e);
    begin
      @(posedge clk_in);
      loop_current_in <= x;
      repeat (100) @(posedge clk_in);
      #1 chk(point_display_value_cmd, e);
    end
  endtask
  // Types the two leading digits, the rest stay zero
  task edit(input [3:0] d0, input [3:0] d1);
    begin
      u_op.press(2'h2);
      chk(menu, `PWL_S_EDIT);
      repeat (d0) u_op.press(2'h0);
      u_op.press(2'h2);
      chk(pos, 3'h1);
      repeat (d1) u_op.press(2'h0);
      chk(dig, {d0, d1, 12'h000});
      u_op.press(2'h3);
    end
  endtask
  task t_interp;
    begin
      chk(tot, 5'h01);
      meas(16'h2ee0, 20'h001f4);
      meas(16'h07d0, 20'hfff83);
      meas(16'h5208, 20'h00426);
    end
  endtask
  task t_add;
    begin
      u_op.press(2'h2);
      chk(sub, `PWL_SUB_ADD);
      u_op.press(2'h2);
      chk(menu, `PWL_S_ADD);
      u_op.press(2'h0);
      chk(idx, 5'h01);
      u_op.press(2'h2);
      chk(tot, 5'h02);
      chk(idx, 5'h02);
      u_op.press(2'h3);
      chk(sub, `PWL_SUB_ADD);
    end
  endtask
  task t_del;
    begin
      u_op.press(2'h0);
      u_op.press(2'h2);
      chk(menu, `PWL_S_DEL);
      u_op.press(2'h0);
      u_op.press(2'h2);
      chk(tot, 5'h01);
      u_op.press(2'h2);
      chk(tot, 5'h01);
      u_op.press(2'h3);
      chk(sub, `PWL_SUB_DEL);
      meas(16'h2ee0, 20'h001f4);
    end
  endtask
  task t_cur;
    begin
      u_op.press(2'h0);
      u_op.press(2'h2);
      chk(menu, `PWL_S_INSEL);
      chk(idx, 5'h00);
      edit(4'h1, 4'h2);
      chk(fail, 1'b0);
      meas(16'h3e80, 20'h001f4);
      edit(4'h2, 4'h0);
      chk(fail, 1'b1);
      meas(16'h3e80, 20'h001f4);
      u_op.press(2'h0);
      edit(4'h2, 4'h2);
      chk(fail, 1'b1);
      meas(16'h3e80, 20'h001f4);
      u_op.press(2'h3);
      u_op.press(2'h3);
      chk(menu, `PWL_S_TOP);
    end
  endtask
  task t_range;
    begin
      @(posedge clk_in);
      lin_enable_in <= 1'b0;
      linear_value_in <= 20'h00007;
      linear_under_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1 chk(point_display_value_cmd, 20'h00007);
      chk(und, 1'b1);
      @(posedge clk_in);
      lin_enable_in <= 1'b1;
      linear_under_in <= 1'b0;
      linear_over_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1 chk(ovr, 1'b1);
      chk(und, 1'b0);
      meas(16'h3e80, 20'h001f4);
    end
  endtask
  // Negative display value typed through the sign position
  task t_point_display_value_cmd;
    begin
      u_op.press(2'h2);
      u_op.press(2'h0);
      chk(sub, `PWL_SUB_POINT_DISPLAY_VALUE_CMD);
      u_op.press(2'h2);
      chk(menu, `PWL_S_DSPSEL);
      u_op.press(2'h0);
      u_op.press(2'h2);
      chk(neg, 1'b0);
      u_op.press(2'h2);
      repeat (2) u_op.press(2'h0);
      repeat (4) u_op.press(2'h2);
      chk(pos, `PWL_SIGN_DIGIT);
      chk(dig, 20'h02000);
      u_op.press(2'h0);
      chk(neg, 1'b1);
      u_op.press(2'h3);
      chk(menu, `PWL_S_DSPSEL);
      meas(16'h3e80, 20'hffc18);
      u_op.press(2'h3);
      u_op.press(2'h3);
      chk(menu, `PWL_S_TOP);
    end
  endtask
  task t_restore;
    begin
      @(posedge clk_in);
      factory_restore_in <= 1'b1;
      @(posedge clk_in);
      factory_restore_in <= 1'b0;
      meas(16'h4e20, 20'h02710);
      meas(16'h2ee0, 20'h01388);
      chk(tot, 5'h01);
      chk(idx, 5'h00);
      @(posedge clk_in);
      five_digit_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      factory_restore_in <= 1'b1;
      @(posedge clk_in);
      factory_restore_in <= 1'b0;
      meas(16'h4e20, 20'h003e8);
    end
  endtask
  task results;
    begin
      if (fails == 0 && checks_done > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    fails = 0;
    checks_done = 0;
    reset_in = 1'b1;
    five_digit_in = 1'b1;
    lin_enable_in = 1'b1;
    loop_current_in = 16'h0fa0;
    linear_value_in = 20'h00000;
    linear_under_in = 1'b0;
    linear_over_in = 1'b0;
    factory_restore_in = 1'b0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_interp;
    t_add;
    t_del;
    t_cur;
    t_range;
    t_point_display_value_cmd;
    t_restore;
    results;
  end
  // Whole run needs under two thousand cycles
  initial begin
    #100000;
    fails = fails + 1;
    results;
  end
endmodule

/* File: include/pwl_defs.vh */
// Constants for the piecewise-linear lineariser and its front-panel editor
`ifndef PWL_DEFS_VH
`define PWL_DEFS_VH
// Table size
`define PWL_MAX_PTS 17
`define PWL_MIN_PTS 5'd2
`define PWL_LAST_IDX 5'h10
// Currents are held in microamps
`define PWL_CUR_MIN 17'd3800
`define PWL_CUR_MAX 17'd21000
`define PWL_DEF_CUR0 16'd4000
`define PWL_DEF_CUR1 16'd20000
// Factory display counts: 0.0/100.0 four digit, 0.00/100.00 five digit
`define PWL_DEF_DISP0 20'sd0
`define PWL_DEF_DISP1_4D 20'sd1000
`define PWL_DEF_DISP1_5D 20'sd10000
// Editor digit layout
`define PWL_DIGITS 5
`define PWL_SIGN_DIGIT 3'd5
// Menu states
`define PWL_S_TOP 3'd0
`define PWL_S_SUB 3'd1
`define PWL_S_ADD 3'd2
`define PWL_S_DEL 3'd3
`define PWL_S_INSEL 3'd4
`define PWL_S_DSPSEL 3'd5
`define PWL_S_EDIT 3'd6
// Sub-menu entries
`define PWL_SUB_ADD 2'd0
`define PWL_SUB_DEL 2'd1
`define PWL_SUB_IN 2'd2
`define PWL_SUB_POINT_DISPLAY_VALUE_CMD 2'd3
// Divider length
`define PWL_DIV_BITS 6'd40
`endif

/* File: verilog/pwl_div.v */
// Sequential unsigned divider used by the interpolation engine
`timescale 1ns/100ps
`include "pwl_defs.vh"
module pwl_div (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Operands
  input wire start_in,
  input wire [39:0] num_in,
  input wire [15:0] den_in,
  // Result
  output reg done_out,
  output reg [39:0] quot_out
);
  reg [16:0] rem_ff;
  reg [39:0] num_ff;
  reg [15:0] den_ff;
  reg [5:0] cnt_ff;
  reg busy_ff;
  wire [16:0] trial;

  // One quotient bit per clock; a whole division takes forty cycles
  assign trial = {rem_ff[15:0], num_ff[39]} - {1'b0, den_ff};

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rem_ff <= 17'h0;
      num_ff <= 40'h0;
      den_ff <= 16'h0;
      cnt_ff <= 6'h0;
      busy_ff <= 1'b0;
      done_out <= 1'b0;
      quot_out <= 40'h0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_ff) begin
        rem_ff <= 17'h0;
        num_ff <= num_in;
        den_ff <= den_in;
        cnt_ff <= `PWL_DIV_BITS;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (!trial[16]) begin
          rem_ff <= trial;
          num_ff <= {num_ff[38:0], 1'b1};
        end else begin
          rem_ff <= {rem_ff[15:0], num_ff[39]};
          num_ff <= {num_ff[38:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 6'h1;
        if (cnt_ff == 6'h1) begin
          busy_ff <= 1'b0;
          done_out <= 1'b1;
          quot_out <= trial[16] ? {num_ff[38:0], 1'b0}
                                : {num_ff[38:0], 1'b1};
        end
      end
    end
  end
endmodule

/* File: verilog/pwl_lineariser.v */
// Piecewise-linear lineariser with front-panel break-point editor
`timescale 1ns/100ps
`include "pwl_defs.vh"
module pwl_lineariser (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Front-panel buttons and model strap (pins)
  input wire key_up_in,
  input wire key_down_in,
  input wire key_confirm_in,
  input wire key_escape_in,
  input wire five_digit_in,
  // Measurement path (same clock)
  input wire lin_enable_in,
  input wire [15:0] loop_current_in,
  input wire signed [19:0] linear_value_in,
  input wire linear_under_in,
  input wire linear_over_in,
  input wire factory_restore_in,
  // Display and menu status
  output reg signed [19:0] display_value_out,
  output reg under_range_out,
  output reg over_range_out,
  output reg [2:0] menu_state_out,
  output reg [1:0] sub_prompt_out,
  output reg [4:0] point_index_out,
  output reg [4:0] point_total_out,
  output reg [19:0] edit_digits_out,
  output reg edit_negative_out,
  output reg [2:0] edit_digit_pos_out,
  output reg fail_out
);
  // Key synchronisers and edge detect
  reg [3:0] key_s1_ff, key_s2_ff, key_s3_ff;
  reg strap_s1_ff, strap_s2_ff;
  wire [3:0] press = key_s2_ff & ~key_s3_ff;
  wire p_up = press[0];
  wire p_dn = press[1];
  wire p_ok = press[2];
  wire p_esc = press[3];

  // Table; never cleared by mode changes, so it survives function swaps
  reg [15:0] cur_ff [0:`PWL_MAX_PTS-1];
  reg signed [19:0] point_display_value_cmd_ff [0:`PWL_MAX_PTS-1];
  reg [4:0] count_ff;
  reg [4:0] sel_ff;
  reg [2:0] state_ff;
  reg [1:0] sub_ff;
  reg [1:0] last_ad_ff;
  reg edit_cur_ff;
  reg [19:0] bcd_ff;
  reg neg_ff;
  reg [2:0] dig_ff;
  reg fail_ff;
  integer i;

  function [3:0] bcd_step;
    input [3:0] d;
    input up;
    begin
      if (up)
        bcd_step = (d == 4'h9) ? 4'h0 : d + 4'h1;
      else
        bcd_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
    end
  endfunction

  function [16:0] bcd_val;
    input [19:0] b;
    begin
      bcd_val = b[19:16] * 17'd10000 + b[15:12] * 17'd1000 +
        b[11:8] * 17'd100 + b[7:4] * 17'd10 + {13'h0, b[3:0]};
    end
  endfunction

  // Typed value checks
  wire [16:0] typed = bcd_val(bcd_ff);
  wire [4:0] sel_lo = (sel_ff == 5'h0) ? 5'h0 : sel_ff - 5'h1;
  wire [4:0] sel_hi = (sel_ff == `PWL_LAST_IDX) ? sel_ff : sel_ff + 5'h1;
  wire in_range = typed >= `PWL_CUR_MIN && typed <= `PWL_CUR_MAX;
  wire above_lo = sel_ff == 5'h0 || typed > {1'b0, cur_ff[sel_lo]};
  wire below_hi = sel_ff == count_ff - 5'h1 ||
    typed < {1'b0, cur_ff[sel_hi]};
  wire cur_ok = in_range && above_lo && below_hi;
  wire [19:0] typed_point_display_value_cmd = neg_ff ? -{3'h0, typed} : {3'h0, typed};
  wire [4:0] sel_max = count_ff - 5'h1;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      key_s1_ff <= 4'h0;
      key_s2_ff <= 4'h0;
      key_s3_ff <= 4'h0;
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else begin
      key_s1_ff <= {key_escape_in, key_confirm_in, key_down_in, key_up_in};
      key_s2_ff <= key_s1_ff;
      key_s3_ff <= key_s2_ff;
      strap_s1_ff <= five_digit_in;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // Menu and table editor
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (i = 0; i < `PWL_MAX_PTS; i = i + 1) begin
        cur_ff[i] <= `PWL_DEF_CUR1;
        point_display_value_cmd_ff[i] <= `PWL_DEF_DISP0;
      end
      cur_ff[0] <= `PWL_DEF_CUR0;
      point_display_value_cmd_ff[1] <= `PWL_DEF_DISP1_4D;
      count_ff <= `PWL_MIN_PTS;
      sel_ff <= 5'h0;
      state_ff <= `PWL_S_TOP;
      sub_ff <= `PWL_SUB_ADD;
      last_ad_ff <= `PWL_SUB_ADD;
      edit_cur_ff <= 1'b0;
      bcd_ff <= 20'h0;
      neg_ff <= 1'b0;
      dig_ff <= 3'h0;
      fail_ff <= 1'b0;
    end else if (factory_restore_in) begin
      // Restore picks the full-scale count for the fitted display
      cur_ff[0] <= `PWL_DEF_CUR0;
      point_display_value_cmd_ff[0] <= `PWL_DEF_DISP0;
      cur_ff[1] <= `PWL_DEF_CUR1;
      point_display_value_cmd_ff[1] <= strap_s2_ff ? `PWL_DEF_DISP1_5D : `PWL_DEF_DISP1_4D;
      count_ff <= `PWL_MIN_PTS;
      sel_ff <= 5'h0;
      fail_ff <= 1'b0;
    end else begin
      if (p_up || p_dn || p_ok || p_esc)
        fail_ff <= 1'b0;
      case (state_ff)
        `PWL_S_TOP: begin
          if (p_ok)
            state_ff <= `PWL_S_SUB;
        end
        `PWL_S_SUB: begin
          if (p_up)
            sub_ff <= sub_ff + 2'h1;
          else if (p_dn)
            sub_ff <= sub_ff - 2'h1;
          else if (p_esc)
            state_ff <= `PWL_S_TOP;
          else if (p_ok) begin
            sel_ff <= 5'h0;
            case (sub_ff)
              `PWL_SUB_ADD: state_ff <= `PWL_S_ADD;
              `PWL_SUB_DEL: state_ff <= `PWL_S_DEL;
              `PWL_SUB_IN: state_ff <= `PWL_S_INSEL;
              default: state_ff <= `PWL_S_DSPSEL;
            endcase
          end
        end
        `PWL_S_ADD, `PWL_S_DEL: begin
          if (p_up && sel_ff < sel_max)
            sel_ff <= sel_ff + 5'h1;
          else if (p_dn && sel_ff != 5'h0)
            sel_ff <= sel_ff - 5'h1;
          else if (p_esc) begin
            state_ff <= `PWL_S_SUB;
            sub_ff <= last_ad_ff;
          end else if (p_ok && state_ff == `PWL_S_ADD) begin
            last_ad_ff <= `PWL_SUB_ADD;
            // New point copies the shown one; it needs calibrating later
            if (count_ff < `PWL_MAX_PTS) begin
              for (i = 1; i < `PWL_MAX_PTS; i = i + 1)
                if (i > sel_ff) begin
                  cur_ff[i] <= cur_ff[i-1];
                  point_display_value_cmd_ff[i] <= point_display_value_cmd_ff[i-1];
                end
              count_ff <= count_ff + 5'h1;
              sel_ff <= sel_ff + 5'h1;
            end
          end else if (p_ok) begin
            last_ad_ff <= `PWL_SUB_DEL;
            if (count_ff > `PWL_MIN_PTS) begin
              for (i = 0; i < `PWL_MAX_PTS - 1; i = i + 1)
                if (i >= sel_ff) begin
                  cur_ff[i] <= cur_ff[i+1];
                  point_display_value_cmd_ff[i] <= point_display_value_cmd_ff[i+1];
                end
              count_ff <= count_ff - 5'h1;
              if (sel_ff == sel_max)
                sel_ff <= sel_ff - 5'h1;
            end
          end
        end
        `PWL_S_INSEL, `PWL_S_DSPSEL: begin
          if (p_up && sel_ff < sel_max)
            sel_ff <= sel_ff + 5'h1;
          else if (p_dn && sel_ff != 5'h0)
            sel_ff <= sel_ff - 5'h1;
          else if (p_esc)
            state_ff <= `PWL_S_SUB;
          else if (p_ok) begin
            state_ff <= `PWL_S_EDIT;
            edit_cur_ff <= state_ff == `PWL_S_INSEL;
            bcd_ff <= 20'h0;
            neg_ff <= 1'b0;
            dig_ff <= 3'h0;
          end
        end
        `PWL_S_EDIT: begin
          if (p_up || p_dn) begin
            if (dig_ff == `PWL_SIGN_DIGIT)
              neg_ff <= ~neg_ff;
            else
              for (i = 0; i < `PWL_DIGITS; i = i + 1)
                if (i == dig_ff)
                  bcd_ff[(4-i)*4 +: 4] <=
                    bcd_step(bcd_ff[(4-i)*4 +: 4], p_up);
          end else if (p_ok) begin
            // Digit position 0 is the most significant; sign only for display
            if (dig_ff == (edit_cur_ff ? 3'h4 : `PWL_SIGN_DIGIT))
              dig_ff <= 3'h0;
            else
              dig_ff <= dig_ff + 3'h1;
          end else if (p_esc) begin
            if (edit_cur_ff) begin
              state_ff <= `PWL_S_INSEL;
              if (cur_ok)
                cur_ff[sel_ff] <= typed[15:0];
              else
                fail_ff <= 1'b1;
            end else begin
              state_ff <= `PWL_S_DSPSEL;
              point_display_value_cmd_ff[sel_ff] <= typed_point_display_value_cmd;
            end
          end
        end
        default: state_ff <= `PWL_S_TOP;
      endcase
    end
  end

  // Segment search; clamping to the end segments extends their slopes
  reg [4:0] seg;
  integer j;
  always @* begin
    seg = 5'h0;
    for (j = 1; j < `PWL_MAX_PTS - 1; j = j + 1)
      if (j <= count_ff - 5'h2 && loop_current_in >= cur_ff[j])
        seg = j[4:0];
  end

  wire [4:0] seg_hi = seg + 5'h1;
  wire signed [16:0] dx = {1'b0, loop_current_in} - {1'b0, cur_ff[seg]};
  wire signed [20:0] dy = {point_display_value_cmd_ff[seg_hi][19], point_display_value_cmd_ff[seg_hi]} -
    {point_display_value_cmd_ff[seg][19], point_display_value_cmd_ff[seg]};
  wire signed [37:0] prod = dx * dy;
  wire [37:0] prod_mag = prod[37] ? -prod : prod;
  wire [15:0] den = cur_ff[seg_hi] - cur_ff[seg];

  reg calc_busy_ff;
  reg prod_neg_ff;
  reg signed [19:0] base_ff;
  wire div_done;
  wire [39:0] quot;
  wire div_start = ~calc_busy_ff;

  pwl_div u_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(div_start),
    .num_in({2'h0, prod_mag}),
    .den_in(den),
    .done_out(div_done),
    .quot_out(quot)
  );

  wire signed [19:0] q_signed = prod_neg_ff ? -quot[19:0] : quot[19:0];

  // Result and status registers
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      calc_busy_ff <= 1'b0;
      prod_neg_ff <= 1'b0;
      base_ff <= 20'sh0;
      display_value_out <= 20'sh0;
      under_range_out <= 1'b0;
      over_range_out <= 1'b0;
      menu_state_out <= `PWL_S_TOP;
      sub_prompt_out <= `PWL_SUB_ADD;
      point_index_out <= 5'h0;
      point_total_out <= 5'h1;
      edit_digits_out <= 20'h0;
      edit_negative_out <= 1'b0;
      edit_digit_pos_out <= 3'h0;
      fail_out <= 1'b0;
    end else begin
      if (div_start) begin
        calc_busy_ff <= 1'b1;
        prod_neg_ff <= prod[37];
        base_ff <= point_display_value_cmd_ff[seg];
      end else if (div_done) begin
        calc_busy_ff <= 1'b0;
        if (lin_enable_in)
          display_value_out <= base_ff + q_signed;
      end
      if (!lin_enable_in)
        display_value_out <= linear_value_in;
      // Range flags come from the linear path in both modes
      under_range_out <= linear_under_in;
      over_range_out <= linear_over_in;
      menu_state_out <= state_ff;
      sub_prompt_out <= sub_ff;
      point_index_out <= sel_ff;
      point_total_out <= count_ff - 5'h1;
      edit_digits_out <= bcd_ff;
      edit_negative_out <= neg_ff;
      edit_digit_pos_out <= dig_ff;
      fail_out <= fail_ff;
    end
  end
endmodule
